// >>> rtl/bsa_array.sv
// Storage array with a bit-masked write port and an asynchronous read port.
`timescale 1ns/1ns
module bsa_array (
    input wire logic core_clk,
    input wire logic ce,
    input wire logic wr_en,
    input wire logic [bsa_pkg::IDX_W-1:0] wr_idx,
    input wire logic [bsa_pkg::DATA_W-1:0] wr_mask,
    input wire logic [bsa_pkg::DATA_W-1:0] wr_data,
    input wire logic [bsa_pkg::IDX_W-1:0] rd_idx,
    output logic [bsa_pkg::DATA_W-1:0] rd_data
);
    import bsa_pkg::*;

    // ****************************************************************
    // Memory words
    // ****************************************************************

    // The array has no reset: its contents after power-up are undefined.
    logic [DATA_W-1:0] mem [2**IDX_W];
    logic [DATA_W-1:0] merged; // Old word with the selected bits replaced.

    // Merge new data only where the mask is set, so other lanes stay unaltered.
    always_comb begin
        merged = (mem[wr_idx] & ~wr_mask) | (wr_data & wr_mask);
    end

    // Write the merged word; a frozen clock enable blocks the write.
    always_ff @(posedge core_clk) begin
        if (ce && wr_en) begin
            mem[wr_idx] <= merged;
        end
    end

    assign rd_data = mem[rd_idx];

endmodule : bsa_array

// >>> rtl/bsa_pkg.sv
// Package of constants, types and helper functions for the burst SRAM access block.
package bsa_pkg;

    // ****************************************************************
    // Word organisations and sizes
    // ****************************************************************

    // The four word organisations that the same core can be built as.
    typedef enum logic [1:0] {BSA_ORG_X8, BSA_ORG_X9, BSA_ORG_X18, BSA_ORG_X36} bsa_org_t;

    // Widest data word; narrower organisations use the low bits only.
    localparam int DATA_W = 36;
    // External address width of this model; kept small so the array fits a simulator.
    localparam int ADDR_W = 4;
    // Internal array index: one more bit than the address, for the burst bit.
    localparam int IDX_W = ADDR_W + 1;
    // Number of byte write selects and nibble write selects.
    localparam int BWS_W = 4;
    localparam int NWS_W = 2;
    // Number of link clock pins sampled by the core clock.
    localparam int CLK_W = 4;
    // Width of everything that crosses from the pins into the core clock.
    localparam int SYNC_W = CLK_W + 2 + ADDR_W + BWS_W + NWS_W + DATA_W;

    // ****************************************************************
    // Reset values and timing counts
    // ****************************************************************

    // Value driven on the data output while nothing is read.
    localparam logic [DATA_W-1:0] DATA_RST = 36'h0_0000_0000;
    // Core cycles after reset before the sampled output clocks are trusted as a strap.
    localparam logic [1:0] STRAP_WAIT = 2'h3;

    // ****************************************************************
    // Lane positions inside a data word
    // ****************************************************************

    localparam logic [DATA_W-1:0] NIB0_MASK = 36'h0_0000_000f;
    localparam logic [DATA_W-1:0] NIB1_MASK = 36'h0_0000_00f0;
    localparam logic [DATA_W-1:0] LANE0_MASK = 36'h0_0000_01ff;
    localparam logic [DATA_W-1:0] LANE1_MASK = 36'h0_0003_fe00;
    localparam logic [DATA_W-1:0] LANE2_MASK = 36'h0_07fc_0000;
    localparam logic [DATA_W-1:0] LANE3_MASK = 36'hf_f800_0000;

    // Turns the active-low selects of one data word into a bit write mask.
    function automatic logic [DATA_W-1:0] lane_mask(
        input bsa_org_t org,
        input logic [BWS_W-1:0] bws_n,
        input logic [NWS_W-1:0] nws_n
    );
        logic [DATA_W-1:0] m;
        m = 36'h0_0000_0000;
        unique case (org)
            BSA_ORG_X8: begin
                // Nibble selects steer the two halves of the byte.
                if (!nws_n[0]) m = m | NIB0_MASK;
                if (!nws_n[1]) m = m | NIB1_MASK;
            end
            BSA_ORG_X9: begin
                // One select covers the whole nine-bit word.
                if (!bws_n[0]) m = LANE0_MASK;
            end
            BSA_ORG_X18: begin
                if (!bws_n[0]) m = m | LANE0_MASK;
                if (!bws_n[1]) m = m | LANE1_MASK;
            end
            BSA_ORG_X36: begin
                // Each lane is independent, so a lone top select leaves [26:0] alone.
                if (!bws_n[0]) m = m | LANE0_MASK;
                if (!bws_n[1]) m = m | LANE1_MASK;
                if (!bws_n[2]) m = m | LANE2_MASK;
                if (!bws_n[3]) m = m | LANE3_MASK;
            end
        endcase
        return m;
    endfunction : lane_mask

    // Array index of the first or second word of a burst.
    function automatic logic [IDX_W-1:0] burst_index(
        input bsa_org_t org,
        input logic [ADDR_W-1:0] addr,
        input logic second
    );
        logic [IDX_W-1:0] idx;
        idx = {1'b0, addr};
        if (org == BSA_ORG_X8 || org == BSA_ORG_X9) begin
            // Narrow words always burst from internal bit zero to one.
            idx = {addr, second};
        end else begin
            // Wide words start at the given address and flip its low bit.
            idx = {1'b0, addr[ADDR_W-1:1], addr[0] ^ second};
        end
        return idx;
    endfunction : burst_index

endpackage : bsa_pkg

// >>> rtl/bsa_sram.sv
// Command decode, burst sequencing, lane masking and read launch of the burst SRAM.
`timescale 1ns/1ns
module bsa_sram #(
    parameter bsa_pkg::bsa_org_t ORG = bsa_pkg::BSA_ORG_X36
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic input_timing_ref,
    input wire logic input_timing_ref_n,
    input wire logic output_timing_ref,
    input wire logic output_timing_ref_n,
    input wire logic load_strobe_n,
    input wire logic read_write_select,
    input wire logic [bsa_pkg::ADDR_W-1:0] address,
    input wire logic [bsa_pkg::BWS_W-1:0] byte_write_select_n,
    input wire logic [bsa_pkg::NWS_W-1:0] nibble_write_select_n,
    input wire logic [bsa_pkg::DATA_W-1:0] dq_in,
    output logic [bsa_pkg::DATA_W-1:0] dq_out,
    output logic dq_oe_n
);
    import bsa_pkg::*;

    // ****************************************************************
    // Pin sampling
    // ****************************************************************

    logic [SYNC_W-1:0] pins_s; // All pins after two core flops.
    logic kin_s; // Sampled positive input clock.
    logic kin_n_s; // Sampled negative input clock.
    logic cout_s; // Sampled positive output clock.
    logic cout_n_s; // Sampled negative output clock.
    logic ld_n_s; // Sampled load strobe.
    logic rw_s; // Sampled read or write select.
    logic [ADDR_W-1:0] addr_s; // Sampled address.
    logic [BWS_W-1:0] bws_n_s; // Sampled byte selects.
    logic [NWS_W-1:0] nws_n_s; // Sampled nibble selects.
    logic [DATA_W-1:0] din_s; // Sampled write data.

    // Clocks, controls and data share one pipe so their relative timing is kept.
    bsa_sync #(.W(SYNC_W)) u_sync (
        .core_clk(core_clk),
        .rst(rst),
        .ce(ce),
        .pin_in({input_timing_ref, input_timing_ref_n, output_timing_ref, output_timing_ref_n,
                 load_strobe_n, read_write_select, address, byte_write_select_n,
                 nibble_write_select_n, dq_in}),
        .sync_out(pins_s)
    );

    assign {kin_s, kin_n_s, cout_s, cout_n_s, ld_n_s, rw_s, addr_s, bws_n_s, nws_n_s,
            din_s} = pins_s;

    // ****************************************************************
    // Edge detection and clock strap
    // ****************************************************************

    logic [CLK_W-1:0] clk_prev_reg; // Clock levels one core cycle ago.
    logic [CLK_W-1:0] clk_prev_next;
    logic [1:0] strap_cnt_reg; // Waits for the sampling pipe to fill.
    logic [1:0] strap_cnt_next;
    logic single_mode_reg; // Output timing taken from the input clocks.
    logic single_mode_next;
    logic k_rise; // Positive input clock rose.
    logic kn_rise; // Negative input clock rose.
    logic oc_rise; // Positive output timing edge.
    logic ocn_rise; // Negative output timing edge.

    // Hold the previous levels and latch the strap once the pipe carries real pins.
    always_comb begin
        clk_prev_next = clk_prev_reg;
        strap_cnt_next = strap_cnt_reg;
        single_mode_next = single_mode_reg;
        if (ce) begin
            clk_prev_next = {kin_s, kin_n_s, cout_s, cout_n_s};
            if (strap_cnt_reg != STRAP_WAIT) begin
                strap_cnt_next = strap_cnt_reg + 2'h1;
                // Both output clocks high at power-on select single clock mode.
                single_mode_next = cout_s & cout_n_s;
            end
        end
    end

    // The strap is caught after release, never from a pin under reset.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            clk_prev_reg <= 4'h0;
            strap_cnt_reg <= 2'h0;
            single_mode_reg <= 1'b0;
        end else begin
            clk_prev_reg <= clk_prev_next;
            strap_cnt_reg <= strap_cnt_next;
            single_mode_reg <= single_mode_next;
        end
    end

    // Rising edges; output timing falls back to the input clocks in single mode.
    // Edges are ignored until the strap is settled, so nothing starts on pipe fill.
    always_comb begin
        k_rise = (strap_cnt_reg == STRAP_WAIT) && kin_s && !clk_prev_reg[3];
        kn_rise = (strap_cnt_reg == STRAP_WAIT) && kin_n_s && !clk_prev_reg[2];
        if (single_mode_reg) begin
            oc_rise = k_rise;
            ocn_rise = kn_rise;
        end else begin
            oc_rise = (strap_cnt_reg == STRAP_WAIT) && cout_s && !clk_prev_reg[1];
            ocn_rise = (strap_cnt_reg == STRAP_WAIT) && cout_n_s && !clk_prev_reg[0];
        end
    end

    // ****************************************************************
    // Write pipeline
    // ****************************************************************

    logic wr_s1_reg; // Waiting for the first word at the next K rise.
    logic wr_s1_next;
    logic [ADDR_W-1:0] wr_s1_addr_reg; // Latched write address.
    logic [ADDR_W-1:0] wr_s1_addr_next;
    logic wr_s2_reg; // Waiting for the second word at the next K_n rise.
    logic wr_s2_next;
    logic [IDX_W-1:0] wr_s2_idx_reg; // Array index of the second word.
    logic [IDX_W-1:0] wr_s2_idx_next;
    logic mem_we; // Array write this core cycle.
    logic [IDX_W-1:0] mem_widx; // Array write index.
    logic [DATA_W-1:0] mem_wmask; // Lanes selected for this word.
    logic cmd_read; // Read command taken this cycle.
    logic cmd_write; // Write command taken this cycle.

    // Commands are taken only on K rises; a high strobe starts nothing.
    assign cmd_read = k_rise && !ld_n_s && rw_s;
    assign cmd_write = k_rise && !ld_n_s && !rw_s;

    // Each word uses the selects sampled with it, so they may differ per word.
    // Writes go straight to the array, so a read that follows sees current data.
    always_comb begin
        wr_s1_next = wr_s1_reg;
        wr_s1_addr_next = wr_s1_addr_reg;
        wr_s2_next = wr_s2_reg;
        wr_s2_idx_next = wr_s2_idx_reg;
        mem_we = 1'b0;
        mem_widx = wr_s2_idx_reg;
        mem_wmask = lane_mask(ORG, bws_n_s, nws_n_s);
        if (ce && k_rise && wr_s1_reg) begin
            // First word at the K rise after the command.
            mem_widx = burst_index(ORG, wr_s1_addr_reg, 1'b0);
            mem_we = |mem_wmask;
            wr_s2_next = 1'b1;
            wr_s2_idx_next = burst_index(ORG, wr_s1_addr_reg, 1'b1);
        end else if (ce && kn_rise && wr_s2_reg) begin
            // Second word at the following K_n rise.
            mem_we = |mem_wmask;
            wr_s2_next = 1'b0;
        end
        if (ce && k_rise) begin
            // A new command may ride the same K rise that takes the first word.
            wr_s1_next = cmd_write;
            wr_s1_addr_next = cmd_write ? addr_s : wr_s1_addr_reg;
        end
    end

    // Register the write pipeline.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            wr_s1_reg <= 1'b0;
            wr_s1_addr_reg <= 4'h0;
            wr_s2_reg <= 1'b0;
            wr_s2_idx_reg <= 5'h00;
        end else begin
            wr_s1_reg <= wr_s1_next;
            wr_s1_addr_reg <= wr_s1_addr_next;
            wr_s2_reg <= wr_s2_next;
            wr_s2_idx_reg <= wr_s2_idx_next;
        end
    end

    // ****************************************************************
    // Storage
    // ****************************************************************

    logic [IDX_W-1:0] mem_ridx; // Array read index.
    logic [DATA_W-1:0] mem_rdata; // Array read data.

    bsa_array u_array (
        .core_clk(core_clk),
        .ce(ce),
        .wr_en(mem_we),
        .wr_idx(mem_widx),
        .wr_mask(mem_wmask),
        .wr_data(din_s),
        .rd_idx(mem_ridx),
        .rd_data(mem_rdata)
    );

    // ****************************************************************
    // Read pipeline and output launch
    // ****************************************************************

    logic rd_s1_reg; // Read taken, waiting for the K rise of t+1.
    logic rd_s1_next;
    logic [ADDR_W-1:0] rd_s1_addr_reg; // Latched read address.
    logic [ADDR_W-1:0] rd_s1_addr_next;
    logic rd_s2_reg; // Waiting for the output negative edge of t+1.
    logic rd_s2_next;
    logic [ADDR_W-1:0] rd_s2_addr_reg;
    logic [ADDR_W-1:0] rd_s2_addr_next;
    logic rd_s3_reg; // Waiting for the output positive edge of t+2.
    logic rd_s3_next;
    logic [ADDR_W-1:0] rd_s3_addr_reg;
    logic [ADDR_W-1:0] rd_s3_addr_next;
    logic rd_seen_reg; // A read has been taken since reset.
    logic rd_seen_next;
    logic [DATA_W-1:0] dq_out_reg; // Launched output word.
    logic [DATA_W-1:0] dq_out_next;
    logic dq_oe_n_reg; // Low while the data pins are driven.
    logic dq_oe_n_next;

    // Only one stage reads the array in a cycle, since the two edges never coincide.
    assign mem_ridx = ocn_rise ? burst_index(ORG, rd_s2_addr_reg, 1'b0)
                               : burst_index(ORG, rd_s3_addr_reg, 1'b1);

    // Stages shift on old values, so a command on the same edge is not skipped ahead.
    always_comb begin
        rd_s1_next = rd_s1_reg;
        rd_s1_addr_next = rd_s1_addr_reg;
        rd_s2_next = rd_s2_reg;
        rd_s2_addr_next = rd_s2_addr_reg;
        rd_s3_next = rd_s3_reg;
        rd_s3_addr_next = rd_s3_addr_reg;
        rd_seen_next = rd_seen_reg;
        dq_out_next = dq_out_reg;
        dq_oe_n_next = dq_oe_n_reg;
        if (ce) begin
            // The stage moves on the K rise of t+1, so a C edge that lags K in cycle t
            // cannot launch the first word a whole cycle early.
            if (k_rise) begin
                rd_s2_next = rd_s1_reg;
                rd_s2_addr_next = rd_s1_addr_reg;
                rd_s1_next = 1'b0;
            end
            if (oc_rise) begin
                rd_s3_next = 1'b0;
                if (rd_s3_reg) begin
                    dq_out_next = mem_rdata;
                    dq_oe_n_next = 1'b0;
                end else begin
                    // No second word waits in rd_s3_reg, so release the pins after this edge.
                    dq_oe_n_next = 1'b1;
                    dq_out_next = DATA_RST;
                end
            end
            if (ocn_rise && rd_s2_reg) begin
                dq_out_next = mem_rdata;
                dq_oe_n_next = 1'b0;
                rd_s3_next = 1'b1;
                rd_s3_addr_next = rd_s2_addr_reg;
                rd_s2_next = 1'b0;
            end
            if (cmd_read) begin
                rd_s1_next = 1'b1;
                rd_s1_addr_next = addr_s;
                rd_seen_next = 1'b1;
            end
        end
    end

    // The pins come up released and stay so until a read is launched.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            rd_s1_reg <= 1'b0;
            rd_s1_addr_reg <= 4'h0;
            rd_s2_reg <= 1'b0;
            rd_s2_addr_reg <= 4'h0;
            rd_s3_reg <= 1'b0;
            rd_s3_addr_reg <= 4'h0;
            rd_seen_reg <= 1'b0;
            dq_out_reg <= DATA_RST;
            dq_oe_n_reg <= 1'b1;
        end else begin
            rd_s1_reg <= rd_s1_next;
            rd_s1_addr_reg <= rd_s1_addr_next;
            rd_s2_reg <= rd_s2_next;
            rd_s2_addr_reg <= rd_s2_addr_next;
            rd_s3_reg <= rd_s3_next;
            rd_s3_addr_reg <= rd_s3_addr_next;
            rd_seen_reg <= rd_seen_next;
            dq_out_reg <= dq_out_next;
            dq_oe_n_reg <= dq_oe_n_next;
        end
    end

    assign dq_out = dq_out_reg;
    assign dq_oe_n = dq_oe_n_reg;

    // ****************************************************************
    // Checks
    // ****************************************************************

    sequence s_first_launch;
        ce && ocn_rise && rd_s2_reg;
    endsequence

    property p_read_first;
        @(posedge core_clk) disable iff (rst) s_first_launch |=> !dq_oe_n_reg && rd_s3_reg;
    endproperty
    a_read_first: assert property (p_read_first) else $error("first read word not launched");

    property p_read_second;
        @(posedge core_clk) disable iff (rst)
            ce && oc_rise && rd_s3_reg |=> !dq_oe_n_reg && (dq_out_reg == $past(mem_rdata));
    endproperty
    a_read_second: assert property (p_read_second) else $error("second read word wrong");

    property p_no_start;
        @(posedge core_clk) disable iff (rst) $rose(rd_s1_reg) |-> $past(cmd_read);
    endproperty
    a_no_start: assert property (p_no_start) else $error("read began without a command");

    property p_powerup_off;
        @(posedge core_clk) disable iff (rst) !dq_oe_n_reg |-> rd_seen_reg;
    endproperty
    a_powerup_off: assert property (p_powerup_off) else $error("pins driven before a read");

    property p_wide_burst;
        @(posedge core_clk) disable iff (rst)
            (ORG == BSA_ORG_X18 || ORG == BSA_ORG_X36) && ce && k_rise && wr_s1_reg
            |=> wr_s2_idx_reg[0] != $past(wr_s1_addr_reg[0]);
    endproperty
    a_wide_burst: assert property (p_wide_burst) else $error("wide burst bit not flipped");

    property p_narrow_burst;
        @(posedge core_clk) disable iff (rst)
            (ORG == BSA_ORG_X8 || ORG == BSA_ORG_X9) && ce && k_rise && wr_s1_reg
            |-> mem_widx[0] == 1'b0 ##1 wr_s2_idx_reg[0] == 1'b1;
    endproperty
    a_narrow_burst: assert property (p_narrow_burst) else $error("narrow burst order wrong");

    property p_empty_mask;
        @(posedge core_clk) disable iff (rst) mem_we |-> (|mem_wmask);
    endproperty
    a_empty_mask: assert property (p_empty_mask) else $error("write with no lane selected");

    // A taken write arms the first word stage with its own address.
    property p_write_timing;
        @(posedge core_clk) disable iff (rst)
            ce && cmd_write |=> wr_s1_reg && (wr_s1_addr_reg == $past(addr_s));
    endproperty
    a_write_timing: assert property (p_write_timing) else $error("write not armed");

    sequence s_first_word;
        ce && k_rise && wr_s1_reg;
    endsequence

    // The armed write lands its first word on the next K rise at the first burst index.
    property p_write_first;
        @(posedge core_clk) disable iff (rst)
            s_first_word |-> (mem_we == (|mem_wmask))
            && (mem_widx == burst_index(ORG, wr_s1_addr_reg, 1'b0));
    endproperty
    a_write_first: assert property (p_write_first) else $error("first write word missed");

endmodule : bsa_sram

// >>> rtl/bsa_sync.sv
// Two-flop synchroniser for a vector of pin inputs.
`timescale 1ns/1ns
module bsa_sync #(
    parameter int W = 1
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic [W-1:0] pin_in,
    output logic [W-1:0] sync_out
);
    import bsa_pkg::*;

    // ****************************************************************
    // Synchroniser stages
    // ****************************************************************

    logic [W-1:0] meta_reg; // First stage; only the second stage reads it.
    logic [W-1:0] meta_next; // Next value of the first stage.
    logic [W-1:0] stab_reg; // Second stage, safe for logic.
    logic [W-1:0] stab_next; // Next value of the second stage.

    // Both stages move together; a low enable freezes the pipe.
    always_comb begin
        meta_next = meta_reg;
        stab_next = stab_reg;
        if (ce) begin
            meta_next = pin_in;
            stab_next = meta_reg;
        end
    end

    // Register the stages; reset clears them to a known level.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            meta_reg <= '0;
            stab_reg <= '0;
        end else begin
            meta_reg <= meta_next;
            stab_reg <= stab_next;
        end
    end

    assign sync_out = stab_reg;

endmodule : bsa_sync

// >>> verification/bsa_ctrl_model.sv
// Behavioural memory controller that makes the link clocks and command pins.
`timescale 1ns/1ns
module bsa_ctrl_model (
    output logic kp,
    output logic kn,
    output logic cp,
    output logic cn,
    output logic ld_n,
    output logic rw,
    output logic [bsa_pkg::ADDR_W-1:0] addr,
    output logic [bsa_pkg::BWS_W-1:0] bws_n,
    output logic [bsa_pkg::DATA_W-1:0] dq
);
    // C idles low, so the single clock strap is never taken.
    initial begin
        {kp, kn, cp, cn} = 4'h5;
        {ld_n, rw, addr, bws_n, dq} = '1;
    end
    // One 125 ns cycle; C trails K by 31 ns to keep the edges apart.
    task automatic cyc(input logic l, r, input logic [3:0] a, b0, b1, input logic [35:0] d0, d1);
        {ld_n, rw, addr, bws_n, dq} = {l, r, a, b0, d0};
        #32 {kp, kn} = 2'h2;
        #31 {cp, cn} = 2'h2;
        {bws_n, dq} = {b1, d1};
        addr = ~a; // Hold is over, so show a changed value.
        #31 {kp, kn} = 2'h1;
        #31 {cp, cn} = 2'h1;
    endtask : cyc
    // Stopped input clocks rest high for a quick restart; C stays put so no read edge is added.
    task automatic halt();
        {kp, kn} = 2'h3;
    endtask : halt
endmodule : bsa_ctrl_model

// >>> verification/burst_sram_access_byte_write_tb_top.sv
// Self-checking bench for the burst SRAM core in its 36-bit organisation.
`timescale 1ns/1ns
module burst_sram_access_byte_write_tb_top;
    import bsa_pkg::*;
    logic core_clk = 0, rst = 1, kp, kn, cp, cn, ld_n, rw, dq_oe_n;
    logic [ADDR_W-1:0] addr, wa;
    logic [BWS_W-1:0] bws_n;
    logic [DATA_W-1:0] dq, dq_out, r1a, r1b, r2b;
    logic [DATA_W-1:0] mem [16]; // Expected array contents.
    logic [DATA_W:0] exp_q[$]; // One {enable_n, data} note per output edge.
    logic r1v = 0, r2v = 0, wp = 0;
    int err_count = 0, samples_checked = 0, seed = 32'h978cf1af;
    always #5 core_clk = ~core_clk;
    bsa_ctrl_model i_bsa_ctrl_model (.kp(kp), .kn(kn), .cp(cp), .cn(cn), .ld_n(ld_n), .rw(rw),
        .addr(addr), .bws_n(bws_n), .dq(dq));
    bsa_sram i_bsa_sram (.core_clk(core_clk), .rst(rst), .ce(1'b1), .input_timing_ref(kp),
        .input_timing_ref_n(kn), .output_timing_ref(cp), .output_timing_ref_n(cn),
        .load_strobe_n(ld_n), .read_write_select(rw), .address(addr),
        .byte_write_select_n(bws_n), .nibble_write_select_n(2'h3), .dq_in(dq),
        .dq_out(dq_out), .dq_oe_n(dq_oe_n));
    // ****************************************************************
    // Checking
    // ****************************************************************
    task automatic chk(input string n, input logic [DATA_W:0] s, e);
        samples_checked++;
        if (s !== e) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    function automatic logic [35:0] msk(input logic [3:0] b);
        for (int i = 0; i < 4; i++) msk[9*i +: 9] = {9{~b[i]}};
    endfunction : msk
    // Output edges settle within three core cycles, so look five cycles on.
    always @(posedge cp or posedge cn) begin
        repeat (5) @(posedge core_clk);
        if (!rst) chk("dq", {dq_oe_n, dq_out}, exp_q.pop_front());
    end
    // ****************************************************************
    // Stimulus: one link cycle per call, notes pushed before its edges
    // ****************************************************************
    task automatic step(input logic l, r, input logic [3:0] a, input logic f);
        logic [DATA_W-1:0] d0, d1;
        logic [BWS_W-1:0] b0, b1;
        d0 = DATA_W'({$random(seed), $random(seed)});
        d1 = DATA_W'({$random(seed), $random(seed)});
        b0 = f ? 4'h0 : 4'($random(seed));
        b1 = f ? 4'h0 : 4'($random(seed));
        if (wp) begin
            mem[wa] = mem[wa] & ~msk(b0) | d0 & msk(b0);
            mem[wa ^ 4'h1] = mem[wa ^ 4'h1] & ~msk(b1) | d1 & msk(b1);
        end
        exp_q.push_back(r2v ? {1'b0, r2b} : {1'b1, DATA_RST});
        exp_q.push_back(r1v ? {1'b0, r1a} : exp_q[$]);
        {r2v, r2b} = {r1v, r1b};
        r1v = !l && r;
        {r1a, r1b} = {mem[a], mem[a ^ 4'h1]};
        {wp, wa} = {!l && !r, a};
        i_bsa_ctrl_model.cyc(l, r, a, b0, b1, d0, d1);
    endtask : step
    task automatic give_verdict();
        $display("checks %0d errors %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : give_verdict
    // Fill every word, then mix random commands; a read is never followed by a write.
    initial begin
        logic l, r;
        repeat (20) @(posedge core_clk);
        #4 rst = 0;
        repeat (6) @(posedge core_clk);
        // This offset keeps every link pin change off a core clock edge.
        #4;
        // The closing no-operation carries the data of the last fill write with all lanes on.
        for (int i = 0; i < 18; i += 2) step(i > 14, 1'b0, 4'(i), 1'b1);
        for (int i = 0; i < 300; i++) begin
            {l, r} = 2'($random(seed));
            if (r1v && !r) l = 1'b1;
            step(l, r, 4'($random(seed)), 1'b0);
        end
        repeat (3) step(1'b1, 1'b0, 4'h0, 1'b0);
        i_bsa_ctrl_model.halt();
        repeat (8) @(posedge core_clk);
        if (exp_q.size() != 0) err_count++;
        give_verdict();
    end
endmodule : burst_sram_access_byte_write_tb_top
